/* logic/sfp_id_store.sv */
`timescale 1ns/1ps
`default_nettype none

// holds the expected id bytes; read data registered
module sfp_id_store
  import sfp_pkg::*;
#(
  parameter int unsigned DEPTH = ID_BYTES
)
(
  // clock and reset
  input  wire logic                clk_i,
  input  wire logic                rst_b_i,
  // load port
  input  wire logic                wr_en_i,
  input  wire logic [ID_IDX_W-1:0] wr_idx_i,
  input  wire logic [7:0]          wr_data_i,
  // read port
  input  wire logic [ID_IDX_W-1:0] rd_idx_i,
  output logic      [7:0]          rd_data_o
);

  logic [7:0] mem_q [DEPTH];

  always_ff @(posedge clk_i)
  begin
    if (wr_en_i)
    begin
      mem_q[wr_idx_i] <= wr_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rd_data_o <= 8'h00;
    end
    else
    begin
      rd_data_o <= mem_q[rd_idx_i];
    end
  end

endmodule : sfp_id_store

`default_nettype wire

/* logic/sfp_pkg.sv */
package sfp_pkg;

  // ----------------------------------------------------------------
  // link framing
  // ----------------------------------------------------------------
  localparam int unsigned UNIT_BITS      = 8;
  localparam int unsigned BIT_CNT_W      = 4;
  localparam int unsigned ID_BYTES       = 7;
  localparam int unsigned ID_IDX_W       = 3;
  localparam int unsigned ADDR_W         = 24;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  TX_RESET_BYTE  = 8'hff;
  localparam logic        BUSY_RESET     = 1'b1;
  localparam logic        LINE_IDLE      = 1'b1;

  // ----------------------------------------------------------------
  // oscillator cycles required while reset is held (met by the host)
  // ----------------------------------------------------------------
  localparam int unsigned RESET_OSC_CYCLES = 20;

  // ----------------------------------------------------------------
  // memory side grouping
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              req;
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wdata;
  } sfp_mem_req_t;

  typedef struct packed {
    logic       ack;
    logic [7:0] rdata;
  } sfp_mem_rsp_t;

endpackage : sfp_pkg

/* logic/sfp_port.sv */
`timescale 1ns/1ps
`default_nettype none

// How it works
// - programming mode entered when reset releases with mode pin at high voltage
// - transfer clock is only an input; host makes it for both directions
// - busy goes low when ready to receive, high as reception starts
// - receive bits are sampled on rising transfer clock edges
// - transmit bits change on falling transfer clock edges
// - all transfers are eight-bit units, least significant bit first
// - busy stays high during transfers and during erase or program
// - a seven-byte id code guards access to non-blank flash
// - commands refused when flash not blank and id mismatches; the guard here blocks only writes, reads still pass
// - only user area may be rewritten; boot area writes blocked
// - memory or status contents returned after the matching command
module sfp_port
  import sfp_pkg::*;
#(
  parameter logic [ADDR_W-1:0] BOOT_BASE = 24'h0f0000,
  parameter logic [ADDR_W-1:0] BOOT_TOP  = 24'h0fffff
)
(
  // clock and reset
  input  wire logic               mclk_i,
  input  wire logic               rst_b_i,
  // mode strap
  input  wire logic               mode_select_pin_i,
  output logic                    prog_mode_o,
  // serial link
  input  wire logic               transfer_clock_input_i,
  input  wire logic               serial_receive_line_i,
  output logic                    serial_transmit_line_o,
  output logic                    busy_output_pin_o,
  // byte stream to the control program
  output logic                    rx_valid_o,
  output logic [7:0]              rx_byte_o,
  input  wire logic               tx_load_i,
  input  wire logic [7:0]         tx_byte_i,
  input  wire logic               ready_i,
  // id check
  input  wire logic               id_load_i,
  input  wire logic [ID_IDX_W-1:0] id_idx_i,
  input  wire logic [7:0]         id_byte_i,
  input  wire logic               id_cmp_i,
  input  wire logic               id_done_i,
  input  wire logic               flash_blank_i,
  output logic                    id_ok_o,
  output logic                    cmd_accept_o,
  // flash operations
  input  wire logic               flash_busy_i,
  input  wire sfp_mem_req_t       mem_req_i,
  output sfp_mem_req_t            mem_req_o,
  output logic                    wr_blocked_o
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_s1_q;
  logic rst_s2_q;

  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  logic rst_n;
  assign rst_n = rst_s2_q;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] sclk_s_q;
  logic [1:0] rxd_s_q;
  logic [1:0] mode_s_q;
  logic       sclk_prev_q;

  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sclk_s_q    <= {2{LINE_IDLE}};
      rxd_s_q     <= {2{LINE_IDLE}};
      mode_s_q    <= 2'h0;
      sclk_prev_q <= LINE_IDLE;
    end
    else
    begin
      sclk_s_q    <= {sclk_s_q[0], transfer_clock_input_i};
      rxd_s_q     <= {rxd_s_q[0], serial_receive_line_i};
      mode_s_q    <= {mode_s_q[0], mode_select_pin_i};
      sclk_prev_q <= sclk_s_q[1];
    end
  end

  logic sclk_rise;
  logic sclk_fall;
  assign sclk_rise = sclk_s_q[1] & ~sclk_prev_q;
  assign sclk_fall = ~sclk_s_q[1] & sclk_prev_q;

  // ----------------------------------------------------------------
  // mode strap capture
  // ----------------------------------------------------------------
  // caught once after the synchroniser has filled; later changes ignored
  logic       strap_done_q;
  logic [1:0] strap_wait_q;

  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      strap_done_q <= 1'b0;
      strap_wait_q <= 2'h0;
      prog_mode_o  <= 1'b0;
    end
    else if (!strap_done_q)
    begin
      strap_wait_q <= strap_wait_q + 2'h1;
      if (strap_wait_q == 2'h2)
      begin
        prog_mode_o  <= mode_s_q[1];
        strap_done_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // receive and transmit shift
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_XFER,
    ST_HOLD
  } sfp_state_t;

  sfp_state_t             state_q;
  logic [BIT_CNT_W-1:0]   bit_cnt_q;
  logic [7:0]             rx_sh_q;
  logic [7:0]             tx_sh_q;

  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q    <= ST_IDLE;
      bit_cnt_q  <= '0;
      rx_sh_q    <= 8'h00;
      rx_valid_o <= 1'b0;
      rx_byte_o  <= 8'h00;
    end
    else
    begin
      rx_valid_o <= 1'b0;
      case (state_q)
        ST_IDLE:
        begin
          if (prog_mode_o && (sclk_fall || sclk_rise))
          begin
            state_q <= ST_XFER;
          end
          if (prog_mode_o && sclk_rise)
          begin
            rx_sh_q   <= {rxd_s_q[1], rx_sh_q[7:1]};
            bit_cnt_q <= BIT_CNT_W'(1);
          end
        end
        ST_XFER:
        begin
          if (sclk_rise)
          begin
            rx_sh_q   <= {rxd_s_q[1], rx_sh_q[7:1]};
            bit_cnt_q <= bit_cnt_q + BIT_CNT_W'(1);
            if (bit_cnt_q == BIT_CNT_W'(UNIT_BITS - 1))
            begin
              rx_valid_o <= 1'b1;
              rx_byte_o  <= {rxd_s_q[1], rx_sh_q[7:1]};
              bit_cnt_q  <= '0;
              state_q    <= ST_HOLD;
            end
          end
        end
        ST_HOLD:
        begin
          if (ready_i && !flash_busy_i)
          begin
            state_q <= ST_IDLE;
          end
        end
        default:
        begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // tx byte is staged on tx_load_i while state_q is not ST_XFER, so it is in place before the first fall
  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_sh_q                <= TX_RESET_BYTE;
      serial_transmit_line_o <= LINE_IDLE;
    end
    else if (tx_load_i && state_q != ST_XFER)
    begin
      tx_sh_q                <= tx_byte_i;
      serial_transmit_line_o <= tx_byte_i[0];
    end
    else if (sclk_fall && state_q == ST_XFER)
    begin
      serial_transmit_line_o <= tx_sh_q[1];
      tx_sh_q                <= {LINE_IDLE, tx_sh_q[7:1]};
    end
  end

  // ----------------------------------------------------------------
  // busy
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busy_output_pin_o <= BUSY_RESET;
    end
    else
    begin
      busy_output_pin_o <= !prog_mode_o || state_q != ST_IDLE
                           || flash_busy_i || !ready_i;
    end
  end

  // ----------------------------------------------------------------
  // id code check
  // ----------------------------------------------------------------
  logic [7:0]          id_exp;
  logic                id_mis_q;

  sfp_id_store #(
    .DEPTH (ID_BYTES)
  ) u_id (
    .clk_i     (mclk_i),
    .rst_b_i   (rst_n),
    .wr_en_i   (id_load_i),
    .wr_idx_i  (id_idx_i),
    .wr_data_i (id_byte_i),
    .rd_idx_i  (id_idx_i),
    .rd_data_o (id_exp)
  );

  // compare one cycle after id_idx_i is presented, registered read
  logic       cmp_q;
  logic [7:0] cmp_byte_q;

  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cmp_q      <= 1'b0;
      cmp_byte_q <= 8'h00;
      id_mis_q   <= 1'b0;
      id_ok_o    <= 1'b0;
    end
    else
    begin
      cmp_q      <= id_cmp_i;
      cmp_byte_q <= id_byte_i;
      if (id_cmp_i && id_idx_i == '0)
      begin
        id_mis_q <= 1'b0;
      end
      else if (cmp_q && cmp_byte_q != id_exp)
      begin
        id_mis_q <= 1'b1;
      end
      if (id_done_i)
      begin
        id_ok_o <= !(id_mis_q || (cmp_q && cmp_byte_q != id_exp));
      end
    end
  end

  assign cmd_accept_o = flash_blank_i || id_ok_o;

  // ----------------------------------------------------------------
  // rewrite guard
  // ----------------------------------------------------------------
  function automatic logic in_boot(input logic [ADDR_W-1:0] a);
    in_boot = (a >= BOOT_BASE) && (a <= BOOT_TOP);
  endfunction : in_boot

  logic blocked;
  assign blocked = mem_req_i.req && mem_req_i.write
                   && (in_boot(mem_req_i.addr) || !cmd_accept_o);

  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mem_req_o    <= '0;
      wr_blocked_o <= 1'b0;
    end
    else
    begin
      mem_req_o     <= mem_req_i;
      mem_req_o.req <= mem_req_i.req && !blocked;
      wr_blocked_o  <= blocked;
    end
  end

endmodule : sfp_port

`default_nettype wire

/* testbench/sfp_host.sv */
`timescale 1ns/1ps
`default_nettype none
module sfp_host (
  input  wire logic mclk_i,
  input  wire logic txd_i,
  output logic      sclk_o,
  output logic      rxd_o
);
  // link clock stands high between frames
  initial sclk_o = 1'b1;
  initial rxd_o = 1'b1;
  task automatic xfer(input logic [7:0] d, output logic [7:0] q);
    for (int i = 0; i < 8; i++)
    begin
      @(negedge mclk_i);
      sclk_o = 1'b0;
      rxd_o = d[i]; // lsb first, set up for the rise
      repeat (4) @(negedge mclk_i);
      sclk_o = 1'b1;
      q[i] = txd_i; // device moved it on the fall
      repeat (3) @(negedge mclk_i);
    end
    rxd_o = ~d[7]; // released line must not look held
  endtask : xfer
endmodule : sfp_host
`default_nettype wire

/* testbench/sfp_port_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module sfp_port_checker
  import sfp_pkg::*;
#(
  parameter logic [ADDR_W-1:0] BOOT_BASE = 24'h0f0000,
  parameter logic [ADDR_W-1:0] BOOT_TOP  = 24'h0fffff
)
(
  input wire logic         mclk_i,
  input wire logic         rst_b_i,
  input wire logic         prog_mode_o,
  input wire logic         transfer_clock_input_i,
  input wire logic         serial_transmit_line_o,
  input wire logic         busy_output_pin_o,
  input wire logic         rx_valid_o,
  input wire logic         ready_i,
  input wire logic         flash_blank_i,
  input wire logic         id_ok_o,
  input wire logic         cmd_accept_o,
  input wire logic         flash_busy_i,
  input wire sfp_mem_req_t mem_req_i,
  input wire sfp_mem_req_t mem_req_o,
  input wire logic         wr_blocked_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  logic wr_i;
  logic boot_i;
  assign wr_i   = mem_req_i.req && mem_req_i.write;
  assign boot_i = mem_req_i.addr >= BOOT_BASE && mem_req_i.addr <= BOOT_TOP;
  a_accept_rule: assert property (cmd_accept_o == (flash_blank_i || id_ok_o))
    else $error("accept differs from blank or id");
  a_boot_block: assert property (wr_i && boot_i |=> !mem_req_o.req && wr_blocked_o)
    else $error("boot write passed");
  a_user_write: assert property (wr_i && !boot_i && cmd_accept_o |=> mem_req_o.req)
    else $error("user write lost");
  a_refused_write: assert property (wr_i && !cmd_accept_o |=> !mem_req_o.req)
    else $error("write passed while refused");
  a_read_pass: assert property (mem_req_i.req && !mem_req_i.write |=> mem_req_o == $past(mem_req_i))
    else $error("read not forwarded");
  a_busy_flash: assert property (flash_busy_i |=> busy_output_pin_o)
    else $error("busy low during flash work");
  a_busy_byte: assert property (rx_valid_o |-> busy_output_pin_o)
    else $error("busy low at byte end");
  a_hold_ready: assert property (rx_valid_o ##1 !ready_i [*3] |-> busy_output_pin_o)
    else $error("busy low while not ready");
  a_normal_busy: assert property (!prog_mode_o |-> busy_output_pin_o)
    else $error("busy low outside programming");
  a_rx_start: assert property ($fell(transfer_clock_input_i) && prog_mode_o |-> ##[0:5] busy_output_pin_o)
    else $error("busy not raised at reception");
  a_tx_still: assert property ($rose(transfer_clock_input_i) |=> $stable(serial_transmit_line_o) [*3])
    else $error("tx changed after rise");
  c_byte: cover property (rx_valid_o);
  c_block: cover property (wr_blocked_o);
  c_id: cover property ($rose(id_ok_o));
endmodule : sfp_port_checker
bind sfp_port sfp_port_checker #(.BOOT_BASE(BOOT_BASE), .BOOT_TOP(BOOT_TOP)) u_chk (
  .mclk_i, .rst_b_i, .prog_mode_o, .transfer_clock_input_i, .serial_transmit_line_o,
  .busy_output_pin_o, .rx_valid_o, .ready_i, .flash_blank_i, .id_ok_o, .cmd_accept_o,
  .flash_busy_i, .mem_req_i, .mem_req_o, .wr_blocked_o);
`default_nettype wire

/* testbench/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  import sfp_pkg::*;
  logic mclk_i = 1'b0, rst_b_i = 1'b0, mode = 1'b1, sclk, rxd, txd, busy, prog, rxv;
  logic tx_load = 1'b0, rdy = 1'b1, idl = 1'b0, idc = 1'b0, idd = 1'b0, blank = 1'b1;
  logic fbusy = 1'b0, id_ok, acc, wrb;
  logic [7:0] tx_byte = 8'h00, idb = 8'h00, rxb, rx_got;
  logic [ID_IDX_W-1:0] idx = '0;
  sfp_mem_req_t mreq = '0, mout;
  int n_mismatch = 0, comparisons = 0, cycles = 0;
  always #50 mclk_i = ~mclk_i;
  sfp_port DUT (.mclk_i, .rst_b_i, .mode_select_pin_i(mode), .prog_mode_o(prog),
    .transfer_clock_input_i(sclk), .serial_receive_line_i(rxd), .serial_transmit_line_o(txd),
    .busy_output_pin_o(busy), .rx_valid_o(rxv), .rx_byte_o(rxb), .tx_load_i(tx_load),
    .tx_byte_i(tx_byte), .ready_i(rdy), .id_load_i(idl), .id_idx_i(idx), .id_byte_i(idb),
    .id_cmp_i(idc), .id_done_i(idd), .flash_blank_i(blank), .id_ok_o(id_ok),
    .cmd_accept_o(acc), .flash_busy_i(fbusy), .mem_req_i(mreq), .mem_req_o(mout),
    .wr_blocked_o(wrb));
  sfp_host HOST (.mclk_i, .txd_i(txd), .sclk_o(sclk), .rxd_o(rxd));
  always @(posedge mclk_i) if (rxv) rx_got <= rxb;
  task automatic conclude;
    if (n_mismatch == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  always @(posedge mclk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_mismatch++;
      conclude();
    end
  end
  task automatic chk_bit(input string nm, input logic e, input logic g);
    comparisons++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_bit
  task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_byte
  task automatic wait_idle;
    for (int n = 0; n < 100 && busy !== 1'b0; n++) @(negedge mclk_i);
  endtask : wait_idle
  // one byte each way; host starts once busy is low, or after 100 cycles of waiting
  task automatic t_xfer(input logic [7:0] r, input logic [7:0] t, input logic rd);
    logic [7:0] q;
    wait_idle();
    chk_bit("busy idle", 1'b0, busy);
    tx_load = 1'b1;
    tx_byte = t;
    @(negedge mclk_i);
    tx_load = 1'b0;
    // ready drops only once the frame has begun, so the host never starts on busy high
    fork
      HOST.xfer(r, q);
      begin
        repeat (2) @(negedge mclk_i);
        rdy = rd;
      end
    join
    repeat (6) @(negedge mclk_i);
    chk_byte("rx byte", r, rx_got);
    chk_byte("tx byte", t, q);
  endtask : t_xfer
  task automatic t_id(input logic [7:0] bad);
    for (int i = 0; i < ID_BYTES; i++)
    begin
      idc = 1'b1;
      idx = ID_IDX_W'(i);
      idb = 8'(8'h11 * (i + 1)) ^ ((i == ID_BYTES - 1) ? bad : 8'h00);
      @(negedge mclk_i);
    end
    idc = 1'b0;
    repeat (2) @(negedge mclk_i);
    idd = 1'b1;
    @(negedge mclk_i);
    idd = 1'b0;
    repeat (2) @(negedge mclk_i);
    chk_bit("id ok", bad == 8'h00, id_ok);
    chk_bit("accept", bad == 8'h00, acc);
  endtask : t_id
  task automatic t_mem(input logic w, input logic [23:0] a, input logic e);
    mreq = '{req: 1'b1, write: w, addr: a, wdata: 8'h5a};
    @(negedge mclk_i);
    chk_bit("mem req", e, mout.req);
    chk_bit("blocked", w & ~e, wrb);
    if (e) chk_byte("mem addr", a[23:16], mout.addr[23:16]);
    mreq = '0;
    @(negedge mclk_i);
  endtask : t_mem
  initial
  begin
    repeat (RESET_OSC_CYCLES) @(negedge mclk_i);
    rst_b_i = 1'b1;
    wait_idle();
    chk_bit("prog mode", 1'b1, prog);
    t_xfer(8'ha5, 8'h3c, 1'b1);
    t_xfer(8'h01, 8'h80, 1'b1);
    t_xfer(8'hfe, 8'h7f, 1'b0);
    repeat (10) @(negedge mclk_i);
    chk_bit("busy hold", 1'b1, busy);
    rdy = 1'b1;
    wait_idle();
    chk_bit("busy ready", 1'b0, busy);
    fbusy = 1'b1;
    repeat (3) @(negedge mclk_i);
    chk_bit("busy flash", 1'b1, busy);
    fbusy = 1'b0;
    t_mem(1'b0, 24'h0f0010, 1'b1);
    t_mem(1'b1, 24'h0f0010, 1'b0);
    t_mem(1'b1, 24'h001000, 1'b1);
    for (int i = 0; i < ID_BYTES; i++)
    begin
      idl = 1'b1;
      idx = ID_IDX_W'(i);
      idb = 8'(8'h11 * (i + 1));
      @(negedge mclk_i);
    end
    idl = 1'b0;
    blank = 1'b0;
    t_id(8'h00);
    t_mem(1'b1, 24'h002000, 1'b1);
    t_id(8'h01);
    t_mem(1'b1, 24'h002000, 1'b0);
    rst_b_i = 1'b0;
    mode = 1'b0;
    repeat (RESET_OSC_CYCLES) @(negedge mclk_i);
    rst_b_i = 1'b1;
    repeat (20) @(negedge mclk_i);
    chk_bit("normal mode", 1'b0, prog);
    chk_bit("busy normal", 1'b1, busy);
    conclude();
  end
endmodule : tb
`default_nettype wire
